//--- hdl/ebaal_top.sv
// byte alu datapath with an axi4-lite register slave
// Summary of operation
// - Add two register bytes, with or without the carry, in one cycle.
// - Subtract two register bytes, with or without carry, in one cycle.
// - Subtract an immediate from the destination in one cycle.
// - Subtract an immediate and the carry from the destination.
// - Add an immediate to a high/low pair over two cycles, sign too.
// - Subtract an immediate from a high/low pair over two cycles.
// - And the destination with a register or immediate, Z N V only.
// - Or, or exclusive-or for registers, updating Z N V only.
// - Set masked destination bits by or-ing with the mask.
// - Clear masked bits by and-ing with all-ones minus the mask.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "ebaal_map.svh"
module ebaal_top #(
    parameter int ADDR_W = 8               // axi address width
) (
    input  wire logic              aclk,          // core clock
    input  wire logic              aresetn,       // sync reset, low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
    input  wire logic [2:0]        s_axi_awprot,  // unused protection
    input  wire logic              s_axi_awvalid, // write addr valid
    output logic                   s_axi_awready, // write addr ready
    input  wire logic [31:0]       s_axi_wdata,   // write data
    input  wire logic [3:0]        s_axi_wstrb,   // byte enables
    input  wire logic              s_axi_wvalid,  // write data valid
    output logic                   s_axi_wready,  // write data ready
    output logic [1:0]             s_axi_bresp,   // write response
    output logic                   s_axi_bvalid,  // write resp valid
    input  wire logic              s_axi_bready,  // write resp ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
    input  wire logic [2:0]        s_axi_arprot,  // unused protection
    input  wire logic              s_axi_arvalid, // read addr valid
    output logic                   s_axi_arready, // read addr ready
    output logic [31:0]            s_axi_rdata,   // read data
    output logic [1:0]             s_axi_rresp,   // read response
    output logic                   s_axi_rvalid,  // read data valid
    input  wire logic              s_axi_rready   // read data ready
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                  aw_full_q;
    logic                  w_full_q;
    logic [ADDR_W-1:0]     awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  rvalid_q;
    logic [1:0]            rresp_q;
    logic [31:0]           rdata_q;
    logic [7:0]            opa_q;
    logic [7:0]            opb_q;
    logic [7:0]            oph_q;
    ebaal_pkg::ebaal_flags_t  flags_q;
    ebaal_pkg::ebaal_op_e     op_q;
    ebaal_pkg::ebaal_state_e  state_q;
    logic                  carry_lo_q;
    logic                  zero_lo_q;
    logic                  wr_fire;
    logic                  lane0;
    logic                  busy;
    logic                  op_legal;
    logic                  go;
    logic                  high;
    ebaal_pkg::ebaal_op_e     cur_op;
    logic [7:0]            add_a;
    logic [7:0]            add_b;
    logic                  add_cin;
    logic [7:0]            sum;
    logic                  cout;
    logic                  half;
    logic                  ovf;
    logic [7:0]            lres;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // word-aligned match of a bus address against a register offset
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [7:0] offs);
        hit = (addr[ADDR_W-1:2] == offs[7:2]);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        mapped = hit(addr, `EBAAL_OPA_ADDR) || hit(addr, `EBAAL_OPB_ADDR)
              || hit(addr, `EBAAL_OPH_ADDR) || hit(addr, `EBAAL_CMD_ADDR)
              || hit(addr, `EBAAL_FLG_ADDR);
    endfunction

    function automatic logic is_sub(input ebaal_pkg::ebaal_op_e op);
        is_sub = op inside {ebaal_pkg::subtract_op,
                            ebaal_pkg::subtract_immediate_op,
                            ebaal_pkg::subtract_with_borrow_op,
                            ebaal_pkg::subtract_imm_with_borrow_op,
                            ebaal_pkg::word_subtract_immediate_op};
    endfunction

    function automatic logic uses_carry(input ebaal_pkg::ebaal_op_e op);
        uses_carry = op inside {ebaal_pkg::add_carry_op,
                                ebaal_pkg::subtract_with_borrow_op,
                                ebaal_pkg::subtract_imm_with_borrow_op};
    endfunction

    function automatic logic is_word(input ebaal_pkg::ebaal_op_e op);
        is_word = op inside {ebaal_pkg::word_add_immediate_op,
                             ebaal_pkg::word_subtract_immediate_op};
    endfunction

    function automatic logic is_logic(input ebaal_pkg::ebaal_op_e op);
        is_logic = op[3];
    endfunction

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;
    assign lane0         = wstrb_q[0];

    // address and data are parked independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    // unmapped, busy or illegal commands answer slverr and do nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `EBAAL_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            if (!mapped(awaddr_q)) begin
                bresp_q <= `EBAAL_RESP_SLVERR;
            end else if (hit(awaddr_q, `EBAAL_CMD_ADDR) && lane0
                         && (busy || !op_legal)) begin
                bresp_q <= `EBAAL_RESP_SLVERR;
            end else begin
                bresp_q <= `EBAAL_RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // read data is captured at the address handshake, upper bits zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `EBAAL_RESP_OKAY;
            rdata_q  <= '0;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= mapped(s_axi_araddr) ? `EBAAL_RESP_OKAY
                                             : `EBAAL_RESP_SLVERR;
            rdata_q  <= '0;
            if (hit(s_axi_araddr, `EBAAL_OPA_ADDR)) begin
                rdata_q[7:0] <= opa_q;
            end else if (hit(s_axi_araddr, `EBAAL_OPB_ADDR)) begin
                rdata_q[7:0] <= opb_q;
            end else if (hit(s_axi_araddr, `EBAAL_OPH_ADDR)) begin
                rdata_q[7:0] <= oph_q;
            end else if (hit(s_axi_araddr, `EBAAL_CMD_ADDR)) begin
                rdata_q[`EBAAL_OP_MSB:0] <= op_q;
            end else if (hit(s_axi_araddr, `EBAAL_FLG_ADDR)) begin
                rdata_q[5:0]            <= flags_q;
                rdata_q[`EBAAL_BUSY_BIT] <= busy;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------
    assign busy     = (state_q == ebaal_pkg::st_high);
    assign high     = busy;
    assign op_legal = (wdata_q[`EBAAL_OP_MSB:0] != 4'hF);
    assign go       = wr_fire && hit(awaddr_q, `EBAAL_CMD_ADDR) && lane0
                      && !busy && op_legal;
    assign cur_op   = high ? op_q
                           : ebaal_pkg::ebaal_op_e'(wdata_q[`EBAAL_OP_MSB:0]);

    // the high byte of a word op reuses the adder with a zero operand
    assign add_a   = high ? oph_q : opa_q;
    assign add_b   = high ? 8'h00 : opb_q;
    assign add_cin = high ? carry_lo_q
                   : (uses_carry(cur_op) && flags_q[`EBAAL_FLG_C]);

    ebaal_adder u_adder (
        .a    (add_a),
        .b    (add_b),
        .cin  (add_cin),
        .sub  (is_sub(cur_op)),
        .sum  (sum),
        .cout (cout),
        .half (half),
        .ovf  (ovf)
    );

    // bitwise group; register and immediate forms share the b operand
    always_comb begin
        unique case (cur_op)
            ebaal_pkg::and_op,
            ebaal_pkg::and_immediate_op:   lres = opa_q & opb_q;
            ebaal_pkg::exclusive_or_op:    lres = opa_q ^ opb_q;
            ebaal_pkg::clear_masked_bits_op:
                lres = opa_q & (8'hFF - opb_q);
            default:                       lres = opa_q | opb_q;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer and destination write-back
    // ------------------------------------------------------------

    // a finishing op beats a software write to the same register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= ebaal_pkg::st_idle;
            op_q       <= ebaal_pkg::add_op;
            carry_lo_q <= 1'b0;
            zero_lo_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ebaal_pkg::st_idle: begin
                    if (go) begin
                        op_q       <= cur_op;
                        carry_lo_q <= cout;
                        zero_lo_q  <= (sum == 8'h00);
                        if (is_word(cur_op)) begin
                            state_q <= ebaal_pkg::st_high;
                        end
                    end
                end
                ebaal_pkg::st_high: begin
                    state_q <= ebaal_pkg::st_idle;
                end
                default: begin
                    state_q <= ebaal_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opa_q <= `EBAAL_OPA_RST;
        end else if (go) begin
            opa_q <= is_logic(cur_op) ? lres : sum;
        end else if (wr_fire && lane0 && hit(awaddr_q, `EBAAL_OPA_ADDR)) begin
            opa_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oph_q <= `EBAAL_OPH_RST;
        end else if (high) begin
            oph_q <= sum;
        end else if (wr_fire && lane0 && hit(awaddr_q, `EBAAL_OPH_ADDR)) begin
            oph_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opb_q <= `EBAAL_OPB_RST;
        end else if (wr_fire && lane0 && hit(awaddr_q, `EBAAL_OPB_ADDR)) begin
            opb_q <= wdata_q[7:0];
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------

    // each class touches only its own flags; the rest hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= `EBAAL_FLG_RST;
        end else if (high) begin
            flags_q[`EBAAL_FLG_C] <= cout;
            flags_q[`EBAAL_FLG_Z] <= zero_lo_q && (sum == 8'h00);
            flags_q[`EBAAL_FLG_N] <= sum[7];
            flags_q[`EBAAL_FLG_V] <= ovf;
            flags_q[`EBAAL_FLG_S] <= sum[7] ^ ovf;
        end else if (go && is_logic(cur_op)) begin
            flags_q[`EBAAL_FLG_Z] <= (lres == 8'h00);
            flags_q[`EBAAL_FLG_N] <= lres[7];
            flags_q[`EBAAL_FLG_V] <= 1'b0;
        end else if (go && !is_word(cur_op)) begin
            flags_q[`EBAAL_FLG_C] <= cout;
            flags_q[`EBAAL_FLG_Z] <= (sum == 8'h00);
            flags_q[`EBAAL_FLG_N] <= sum[7];
            flags_q[`EBAAL_FLG_V] <= ovf;
            flags_q[`EBAAL_FLG_H] <= half;
        end else if (wr_fire && lane0 && hit(awaddr_q, `EBAAL_FLG_ADDR)) begin
            flags_q <= wdata_q[5:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence word_done_s;
        busy ##1 !busy;
    endsequence

    add_carry_sum_a: assert property (
        go && cur_op == ebaal_pkg::add_carry_op |=>
        opa_q == $past(opa_q) + $past(opb_q)
                 + {7'h00, $past(flags_q[`EBAAL_FLG_C])})
        else $error("add with carry result wrong");

    sub_borrow_a: assert property (
        go && cur_op == ebaal_pkg::subtract_op |=>
        flags_q[`EBAAL_FLG_C] == ($past(opa_q) < $past(opb_q))
        && opa_q == $past(opa_q) - $past(opb_q))
        else $error("subtract borrow or result wrong");

    sub_imm_half_a: assert property (
        go && cur_op == ebaal_pkg::subtract_immediate_op |=>
        flags_q[`EBAAL_FLG_H] == ($past(opa_q[3:0]) < $past(opb_q[3:0])))
        else $error("immediate subtract half borrow wrong");

    sub_imm_carry_a: assert property (
        go && cur_op == ebaal_pkg::subtract_imm_with_borrow_op |=>
        opa_q == $past(opa_q) - $past(opb_q)
                 - {7'h00, $past(flags_q[`EBAAL_FLG_C])})
        else $error("immediate subtract with carry wrong");

    word_add_pair_a: assert property (
        go && cur_op == ebaal_pkg::word_add_immediate_op |=>
        word_done_s ##0 {oph_q, opa_q} ==
            $past({oph_q, opa_q}, 2) + {8'h00, $past(opb_q, 2)})
        else $error("word add result or timing wrong");

    word_sub_sign_a: assert property (
        go && cur_op == ebaal_pkg::word_subtract_immediate_op |=>
        word_done_s ##0 ({oph_q, opa_q} ==
            $past({oph_q, opa_q}, 2) - {8'h00, $past(opb_q, 2)})
        && flags_q[`EBAAL_FLG_S] ==
           (flags_q[`EBAAL_FLG_N] ^ flags_q[`EBAAL_FLG_V]))
        else $error("word subtract result or sign wrong");

    and_flags_a: assert property (
        go && cur_op == ebaal_pkg::and_immediate_op |=>
        opa_q == ($past(opa_q) & $past(opb_q)) && !flags_q[`EBAAL_FLG_V])
        else $error("and result or overflow flag wrong");

    xor_result_a: assert property (
        go && cur_op == ebaal_pkg::exclusive_or_op |=>
        opa_q == ($past(opa_q) ^ $past(opb_q)))
        else $error("exclusive or result wrong");

    set_bits_a: assert property (
        go && cur_op == ebaal_pkg::set_masked_bits_op |=>
        opa_q == ($past(opa_q) | $past(opb_q)))
        else $error("masked bit set wrong");

    clear_bits_a: assert property (
        go && cur_op == ebaal_pkg::clear_masked_bits_op |=>
        opa_q == ($past(opa_q) & ~$past(opb_q)))
        else $error("masked bit clear wrong");

    logic_keeps_flags_a: assert property (
        go && is_logic(cur_op) |=>
        $stable(flags_q[`EBAAL_FLG_C]) && $stable(flags_q[`EBAAL_FLG_H])
        && $stable(flags_q[`EBAAL_FLG_S])
        && flags_q[`EBAAL_FLG_N] == opa_q[7]
        && flags_q[`EBAAL_FLG_Z] == (opa_q == 8'h00))
        else $error("logic op disturbed flags");

endmodule

//--- hdl/ebaal_map.svh
// register offsets, field positions and reset values of the byte alu
`ifndef EBAAL_MAP_SVH
`define EBAAL_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define EBAAL_OPA_ADDR    8'h00
`define EBAAL_OPB_ADDR    8'h04
`define EBAAL_OPH_ADDR    8'h08
`define EBAAL_CMD_ADDR    8'h0C
`define EBAAL_FLG_ADDR    8'h10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EBAAL_OPA_RST     8'h00
`define EBAAL_OPB_RST     8'h00
`define EBAAL_OPH_RST     8'h00
`define EBAAL_FLG_RST     6'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EBAAL_FLG_C       0
`define EBAAL_FLG_Z       1
`define EBAAL_FLG_N       2
`define EBAAL_FLG_V       3
`define EBAAL_FLG_S       4
`define EBAAL_FLG_H       5
`define EBAAL_BUSY_BIT    8
`define EBAAL_OP_MSB      3

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define EBAAL_RESP_OKAY   2'h0
`define EBAAL_RESP_SLVERR 2'h2

`endif

//--- hdl/ebaal_pkg.sv
// shared types of the byte alu
package ebaal_pkg;

    // operation codes written to the command register
    typedef enum logic [3:0] {
        add_op                      = 4'h0,
        add_carry_op                = 4'h1,
        subtract_op                 = 4'h2,
        subtract_immediate_op       = 4'h3,
        subtract_with_borrow_op     = 4'h4,
        subtract_imm_with_borrow_op = 4'h5,
        word_add_immediate_op       = 4'h6,
        word_subtract_immediate_op  = 4'h7,
        and_op                      = 4'h8,
        and_immediate_op            = 4'h9,
        or_op                       = 4'hA,
        or_immediate_op             = 4'hB,
        exclusive_or_op             = 4'hC,
        set_masked_bits_op          = 4'hD,
        clear_masked_bits_op        = 4'hE
    } ebaal_op_e;

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        st_idle = 2'h1,
        st_high = 2'h2
    } ebaal_state_e;

    typedef logic [5:0] ebaal_flags_t;

endpackage

//--- hdl/ebaal_adder.sv
// eight-bit add and subtract core with carry, half-carry and overflow
`timescale 1ns/100ps
module ebaal_adder (
    input  wire logic [7:0] a,    // minuend or first addend
    input  wire logic [7:0] b,    // subtrahend or second addend
    input  wire logic       cin,  // carry in, borrow in when subtracting
    input  wire logic       sub,  // high to subtract
    output logic      [7:0] sum,  // result byte
    output logic            cout, // carry out, borrow out when subtracting
    output logic            half, // carry or borrow out of bit 3
    output logic            ovf   // two's complement overflow
);
    logic [8:0] full;
    logic [4:0] low;

    // a borrow shows up as the ninth bit of the widened difference
    always_comb begin
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        end
    end

    // sign rule differs: add overflows on like signs, subtract on unlike
    assign sum  = full[7:0];
    assign cout = full[8];
    assign half = low[4];
    assign ovf  = sub ? ((a[7] != b[7]) && (sum[7] != a[7]))
                      : ((a[7] == b[7]) && (sum[7] != a[7]));
endmodule

//--- test/ebaal_host.sv
// axi4-lite master standing in for the decoder and register file
`timescale 1ns/100ps
module ebaal_host (
    input  wire logic        aclk,    // core clock
    output logic [7:0]       awaddr,  // write address
    output logic             awvalid, // write address valid
    input  wire logic        awready, // write address ready
    output logic [31:0]      wdata,   // write data
    output logic [3:0]       wstrb,   // byte enables
    output logic             wvalid,  // write data valid
    input  wire logic        wready,  // write data ready
    input  wire logic [1:0]  bresp,   // write response
    input  wire logic        bvalid,  // write response valid
    output logic [7:0]       araddr,  // read address
    output logic             arvalid, // read address valid
    input  wire logic        arready, // read address ready
    input  wire logic [31:0] rdata,   // read data
    input  wire logic [1:0]  rresp,   // read response
    input  wire logic        rvalid   // read data valid
);
    // idle bus at time zero; ready signals are sampled mid-cycle
    initial begin
        {awvalid, wvalid, arvalid, awaddr, araddr} = '0;
        wdata = 32'h0;
        wstrb = 4'hF;
    end
    // one write; address and data offered together, each held until taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                      output logic [1:0] rs);
        logic ah, wh, bh;
        awaddr  <= ad;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!bh);
    endtask
    // one read; the answer is taken at the edge where rvalid is high
    task automatic rd(input logic [7:0] ad, output logic [31:0] d,
                      output logic [1:0] rs);
        logic ah, rh;
        araddr  <= ad;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ah = arvalid && arready;
            rh = rvalid;
            d  = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
        end while (!rh);
    endtask
endmodule

//--- test/tb_top.sv
// self-checking bench of the byte alu against an integer model
`timescale 1ns/100ps
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic        awvalid, awready, wvalid, wready, bvalid;
    logic        arvalid, arready, rvalid;
    logic [31:0] seed = 32'h7e2af6a0, d;
    int          fail_count = 0, total_checks = 0;
    int          op, a, b, h, fl, ea, eh, ef;
    int          exp_q[$];
    always #25 aclk = ~aclk;
    ebaal_top #(.ADDR_W(8)) i_ebaal_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    ebaal_host i_ebaal_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid));
    // xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // integer model; carry is a borrow on subtracts, s = n ^ v on words
    task automatic model(input int op, b, inout int a, h, fl);
        int r, c, hc, v, w, n, cin;
        cin = (op == 1 || op == 4 || op == 5) ? (fl & 1) : 0;
        if (op <= 5) begin
            r  = (op < 2) ? a + b + cin : a - b - cin;
            c  = (op < 2) ? r >> 8 : (r < 0);
            hc = (op < 2) ? ((a & 15) + (b & 15) + cin) >> 4
                          : (((a & 15) - (b & 15) - cin) < 0);
            v  = (op < 2) ? ((~(a ^ b) & (a ^ r) & 128) != 0)
                          : (((a ^ b) & (a ^ r) & 128) != 0);
            r  = r & 255;
            fl = (fl & 16) | (hc << 5) | (v << 3) | ((r >> 7) << 2)
               | ((r == 0) << 1) | c;
            a  = r;
        end else if (op <= 7) begin
            w  = (h << 8) | a;
            r  = (op == 6) ? w + b : w - b;
            c  = (op == 6) ? r >> 16 : (r < 0);
            r  = r & 65535;
            v  = (op == 6) ? ((~w & r & 32768) != 0) : ((w & ~r & 32768) != 0);
            n  = r >> 15;
            fl = (fl & 32) | ((n ^ v) << 4) | (v << 3) | (n << 2)
               | ((r == 0) << 1) | c;
            a  = r & 255;
            h  = r >> 8;
        end else begin
            r  = (op <= 9) ? a & b : (op == 12) ? a ^ b
               : (op == 14) ? a & (255 - b) : a | b;
            fl = (fl & 49) | ((r >> 7) << 2) | ((r == 0) << 1);
            a  = r;
        end
    endtask
    // watchdog well beyond the expected thousand or so cycles
    initial begin
        #(50 * 20000);
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            i_ebaal_host.rd(8'(4 * i), d, rs);
            chk(d, 32'h0);
        end
        // unmapped place and the illegal opcode are both refused
        i_ebaal_host.rd(8'h14, d, rs);
        chk({rs, d[29:0]}, 32'h80000000);
        i_ebaal_host.wr(8'h0C, 32'hF, rs);
        chk(rs, 32'h2);
        // every opcode three times over random operands and flags
        for (int k = 0; k < 45; k++) begin
            op = k % 15;
            a  = rnd() & 255;
            b  = rnd() & 255;
            h  = rnd() & 255;
            fl = rnd() & 63;
            ea = a;
            eh = h;
            ef = fl;
            model(op, b, ea, eh, ef);
            // expected readbacks in the order they are fetched below
            exp_q = {ea, eh, ef, op};
            i_ebaal_host.wr(8'h10, fl, rs);
            i_ebaal_host.wr(8'h00, a, rs);
            i_ebaal_host.wr(8'h04, b, rs);
            i_ebaal_host.wr(8'h08, h, rs);
            i_ebaal_host.wr(8'h0C, op, rs);
            chk(rs, 32'h0);
            i_ebaal_host.rd(8'h00, d, rs);
            chk(d, exp_q.pop_front());
            i_ebaal_host.rd(8'h08, d, rs);
            chk(d, exp_q.pop_front());
            i_ebaal_host.rd(8'h10, d, rs);
            chk(d, exp_q.pop_front());
            i_ebaal_host.rd(8'h0C, d, rs);
            chk(d, exp_q.pop_front());
        end
        wrap_up();
    end
endmodule
